// ---- dv/amss_rd_monitor.sv ----
// Concurrent checks on the ports of the strobe-select read sequencer.
`timescale 1ns/1ps
`include "amss_rd_cfg.svh"

module amss_rd_monitor #(
   parameter int NUM_CS = 4,
   parameter int ADDR_W = 22
) (
   input wire logic clk, // Interface clock
   input wire logic rst, // Synchronous reset
   input wire logic req_valid, // Request present
   input wire logic req_ready, // Request taken
   input wire logic rd_valid, // Word done
   input wire logic wr_pending, // Write waiting
   input wire logic wr_handoff, // Write may start
   input wire logic busy, // Not idle
   input wire logic [NUM_CS-1:0] cfg_strobe_sel, // Mode per region
   input wire logic [NUM_CS*`ASRD_STROBE_W-1:0] cfg_rd_strobe, // Strobe field per region
   input wire logic [NUM_CS-1:0] ext_chip_select_n, // Chip selects
   input wire logic ext_output_enable_n, // Output enable
   input wire logic ext_write_enable_n, // Write enable
   input wire logic ext_direction, // Direction
   input wire logic ext_data_oe, // Data drive enable
   input wire logic [ADDR_W-1:0] ext_addr_bus, // Address
   input wire logic [`ASRD_BANK_W-1:0] ext_bank_sel // Bank
);
   logic [7:0] s_cnt_r;
   logic [7:0] s_len;
   logic [$clog2(NUM_CS)-1:0] rgn_r;
   logic ss_all;

   assign ss_all = &cfg_strobe_sel;
   assign s_len = 8'(cfg_rd_strobe[rgn_r*`ASRD_STROBE_W +: `ASRD_STROBE_W]) + 8'h01;

   // Strobe length counter and region of the running strobe
   always_ff @(posedge clk) begin
      if (rst || ext_output_enable_n) s_cnt_r <= 8'h00;
      else s_cnt_r <= s_cnt_r + 8'h01;
   end
   always_ff @(posedge clk) begin
      for (int i = 0; i < NUM_CS; i++) begin
         if (!ext_chip_select_n[i]) rgn_r <= i[$clog2(NUM_CS)-1:0];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_strobe_start;
      $fell(ext_output_enable_n);
   endsequence
   sequence s_strobe_end;
      $rose(ext_output_enable_n);
   endsequence

   property p_reset;
      disable iff (1'b0) rst |=> &ext_chip_select_n && ext_output_enable_n && !busy && !rd_valid;
   endproperty
   property p_we_dir;
      ext_write_enable_n && ext_direction && !ext_data_oe;
   endproperty
   property p_ss_cs;
      ss_all && ext_output_enable_n |-> &ext_chip_select_n;
   endproperty
   property p_fall;
      s_strobe_start ##0 ss_all |-> $countones(~ext_chip_select_n) == 1 &&
         &$past(ext_chip_select_n);
   endproperty
   property p_rise;
      s_strobe_end ##0 ss_all |-> &ext_chip_select_n;
   endproperty
   property p_strobe_len;
      s_strobe_end |-> s_cnt_r == s_len;
   endproperty
   property p_addr;
      !ext_output_enable_n |-> $stable(ext_addr_bus) && $stable(ext_bank_sel);
   endproperty
   property p_take;
      req_valid && req_ready |=> !req_ready ##1 1'b1;
   endproperty
   property p_pulse;
      rd_valid |=> !rd_valid;
   endproperty
   property p_idle;
      $rose(rd_valid) && !$past(req_valid) && !$past(wr_pending) |-> !busy;
   endproperty
   property p_handoff;
      wr_handoff |-> $past(wr_pending) ##1 !wr_handoff;
   endproperty

   a_reset: assert property (p_reset) else $error("pins not idle after reset");
   a_we_dir: assert property (p_we_dir) else $error("write pins not idle");
   a_ss_cs: assert property (p_ss_cs) else $error("chip select outside strobe");
   a_fall: assert property (p_fall) else $error("select and enable did not fall together");
   a_rise: assert property (p_rise) else $error("select and enable did not rise together");
   a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
   a_addr: assert property (p_addr) else $error("address moved during strobe");
   a_take: assert property (p_take) else $error("ready stayed after take");
   a_pulse: assert property (p_pulse) else $error("read valid longer than a cycle");
   a_idle: assert property (p_idle) else $error("busy after word with nothing pending");
   a_handoff: assert property (p_handoff) else $error("handoff without pending write");
endmodule // amss_rd_monitor

bind async_mem_strobe_select_read amss_rd_monitor #(.NUM_CS(NUM_CS), .ADDR_W(ADDR_W))
   amss_rd_monitor_inst (
   .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .rd_valid(rd_valid),
   .wr_pending(wr_pending), .wr_handoff(wr_handoff), .busy(busy),
   .cfg_strobe_sel(cfg_strobe_sel), .cfg_rd_strobe(cfg_rd_strobe),
   .ext_chip_select_n(ext_chip_select_n), .ext_output_enable_n(ext_output_enable_n),
   .ext_write_enable_n(ext_write_enable_n), .ext_direction(ext_direction),
   .ext_data_oe(ext_data_oe),
   .ext_addr_bus(ext_addr_bus), .ext_bank_sel(ext_bank_sel)
);

// ---- dv/async_mem_model.sv ----
// Behavioural asynchronous memory that answers reads on the external pins.
`timescale 1ns/1ps
`include "amss_rd_cfg.svh"

module async_mem_model (
   input wire logic clk, // Interface clock
   input wire logic [3:0] cs_n, // Chip selects, active low
   input wire logic oe_n, // Output enable, active low
   input wire logic [21:0] addr, // Memory address
   input wire logic [1:0] bank, // Bank address
   input wire logic slow, // Data valid only from second strobe cycle
   output logic [`ASRD_DATA_W-1:0] dq // Read data
);
   logic [`ASRD_DATA_W-1:0] last = 32'h0000_0000;
   logic late = 1'b0;

   always_ff @(posedge clk) begin
      late <= !oe_n;
      last <= dq;
   end

   // A released bus toggles every cycle so a stale word never looks valid
   assign dq = (!oe_n && !(&cs_n) && (!slow || late)) ?
      {addr[13:0], bank, addr[13:0], bank} : ~last;
endmodule // async_mem_model

// ---- dv/async_mem_strobe_select_read_test.sv ----
// Self-checking bench of the strobe-select read sequencer with a memory model.
`timescale 1ns/1ps
`include "amss_rd_cfg.svh"

module async_mem_strobe_select_read_test;
   typedef struct {
      logic [1:0] rg;
      logic [21:0] a;
      logic [1:0] ta;
      logic [3:0] su;
      logic [5:0] st;
      logic [2:0] ho;
      logic [1:0] sz;
      logic slow;
      int lat;
   } row_t;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic [21:0] req_addr = 22'h00_0000;
   logic [1:0] req_region = 2'h0;
   logic wr_pending = 1'b0;
   logic slow = 1'b0;
   logic [3:0] cfg_strobe_sel = 4'hF;
   logic [7:0] cfg_turnaround = 8'h00;
   logic [15:0] cfg_rd_setup = 16'h0000;
   logic [23:0] cfg_rd_strobe = 24'h00_0000;
   logic [11:0] cfg_rd_hold = 12'h000;
   logic [7:0] cfg_bus_size = 8'h00;
   logic req_ready, rd_valid, wr_handoff, busy, oe_n;
   logic [3:0] cs_n;
   logic [21:0] ext_a;
   logic [1:0] ext_b;
   logic [31:0] rd_data, dq;
   logic cs_early = 1'b0;
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int n_hand = 0;
   int take_q[$];
   int lat_q[$];
   logic [31:0] got_q[$];
   // Latency counts edges from the take to the edge that samples rd_valid
   row_t rows[5] = '{
      '{2'h0, 22'h00_0003, 2'h0, 4'h0, 6'h00, 3'h0, 2'h2, 1'b0, 5},
      '{2'h1, 22'h2A_5A5C, 2'h3, 4'h2, 6'h05, 3'h1, 2'h2, 1'b1, 15},
      '{2'h2, 22'h15_A5A1, 2'h1, 4'h1, 6'h01, 3'h2, 2'h1, 1'b0, 16},
      '{2'h3, 22'h3F_FFFF, 2'h2, 4'hF, 6'h3F, 3'h7, 2'h0, 1'b1, 355},
      '{2'h1, 22'h01_2346, 2'h2, 4'h0, 6'h02, 3'h0, 2'h3, 1'b0, 8}
   };

   initial forever #(`ASRD_CLK_PERIOD_NS / 2) clk = ~clk;

   async_mem_strobe_select_read async_mem_strobe_select_read_inst (
      .clk(clk), .rst(rst), .req_valid(req_valid), .req_addr(req_addr),
      .req_region(req_region), .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .wr_pending(wr_pending), .wr_handoff(wr_handoff), .busy(busy),
      .cfg_strobe_sel(cfg_strobe_sel), .cfg_turnaround(cfg_turnaround),
      .cfg_rd_setup(cfg_rd_setup), .cfg_rd_strobe(cfg_rd_strobe), .cfg_rd_hold(cfg_rd_hold),
      .cfg_bus_size(cfg_bus_size), .ext_chip_select_n(cs_n), .ext_output_enable_n(oe_n),
      .ext_write_enable_n(), .ext_direction(), .ext_addr_bus(ext_a), .ext_bank_sel(ext_b),
      .ext_data_bus(dq), .ext_data_oe()
   );
   async_mem_model async_mem_model_inst (
      .clk(clk), .cs_n(cs_n), .oe_n(oe_n), .addr(ext_a), .bank(ext_b), .slow(slow), .dq(dq)
   );

   // ****************************************
   // Observation and helpers
   // ****************************************
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rst) take_q.delete();
      else if (req_valid && req_ready) take_q.push_back(cyc);
      if (rd_valid === 1'b1) begin
         got_q.push_back(rd_data);
         lat_q.push_back(cyc - take_q.pop_front());
      end
      if (wr_handoff === 1'b1) n_hand <= n_hand + 1;
      if (!(&cs_n) && oe_n) cs_early <= 1'b1;
   end

   function automatic logic [31:0] pat(input logic [21:0] a, input logic [1:0] b);
      return {a[13:0], b, a[13:0], b};
   endfunction
   function automatic logic [31:0] exp_word(input logic [21:0] a, input logic [1:0] sz);
      logic [31:0] w;
      logic [31:0] p;
      logic [22:0] u;
      w = pat(a >> 2, a[1:0]);
      for (int k = 0; k < 4; k++) begin
         u = {a, k[0]};
         p = (sz == 2'h0) ? pat(a, k[1:0]) : pat(u[22:2], u[1:0]);
         if (sz == 2'h0) w[8*k +: 8] = p[7:0];
         if (sz == 2'h1 && k < 2) w[16*k +: 16] = p[15:0];
      end
      return w;
   endfunction

   task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int exp);
      chk_d(got, exp);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic issue(input logic [1:0] rg, input logic [21:0] a);
      req_region <= rg;
      req_addr <= a;
      req_valid <= 1'b1;
      @(posedge clk);
      while (req_ready !== 1'b1) @(posedge clk);
   endtask
   task automatic get(input logic [31:0] ew, input int el);
      while (got_q.size() == 0) @(posedge clk);
      chk_d(got_q.pop_front(), ew);
      chk_n(lat_q.pop_front(), el);
   endtask
   task automatic set_cfg(input row_t r);
      cfg_turnaround[r.rg*2 +: 2] <= r.ta;
      cfg_rd_setup[r.rg*4 +: 4] <= r.su;
      cfg_rd_strobe[r.rg*6 +: 6] <= r.st;
      cfg_rd_hold[r.rg*3 +: 3] <= r.ho;
      cfg_bus_size[r.rg*2 +: 2] <= r.sz;
      slow <= r.slow;
   endtask
   task automatic run_row(input row_t r);
      set_cfg(r);
      @(posedge clk);
      issue(r.rg, r.a);
      req_valid <= 1'b0;
      get(exp_word(r.a, r.sz), r.lat);
      repeat (3) @(posedge clk);
   endtask

   initial begin
      #(3000 * `ASRD_CLK_PERIOD_NS);
      err_count++;
      end_sim();
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (11) @(posedge clk);
      chk_d({24'h00_0000, cs_n, oe_n, busy, rd_valid, req_ready}, 32'h0000_00F8);
      @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      foreach (rows[i]) run_row(rows[i]);
      $display("test table done");
      set_cfg('{2'h0, 22'h00_0000, 2'h3, 4'h0, 6'h01, 3'h0, 2'h2, 1'b0, 0});
      set_cfg('{2'h1, 22'h00_0000, 2'h2, 4'h0, 6'h01, 3'h0, 2'h1, 1'b0, 0});
      @(posedge clk);
      issue(2'h0, 22'h12_3454);
      issue(2'h0, 22'h12_3458);
      issue(2'h1, 22'h0A_BCDE);
      req_valid <= 1'b0;
      get(exp_word(22'h12_3454, 2'h2), 8);
      get(exp_word(22'h12_3458, 2'h2), 5);
      get(exp_word(22'h0A_BCDE, 2'h1), 11);
      $display("test chain done");
      @(posedge clk);
      issue(2'h0, 22'h00_0100);
      req_valid <= 1'b0;
      wr_pending <= 1'b1;
      get(exp_word(22'h00_0100, 2'h2), 8);
      wr_pending <= 1'b0;
      repeat (3) @(posedge clk);
      chk_n(n_hand, 1);
      $display("test handoff done");
      cfg_strobe_sel <= 4'hB;
      chk_d({31'h0000_0000, cs_early}, 32'h0000_0000);
      @(posedge clk);
      issue(2'h2, 22'h15_A5A1);
      req_valid <= 1'b0;
      get(exp_word(22'h15_A5A1, 2'h1), 16);
      chk_d({31'h0000_0000, cs_early}, 32'h0000_0001);
      cfg_strobe_sel <= 4'hF;
      $display("test normal mode done");
      @(posedge clk);
      issue(2'h3, 22'h3F_FFFF);
      req_valid <= 1'b0;
      repeat (25) @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      chk_d({24'h00_0000, cs_n, oe_n, busy, rd_valid, req_ready}, 32'h0000_00F8);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      run_row(rows[0]);
      $display("test mid reset done");
      end_sim();
   end
endmodule // async_mem_strobe_select_read_test

// ---- hdl/async_mem_strobe_select_read.sv ----
// Read sequencer of an asynchronous memory port with strobe-select timing.
//
// Overview of operation
// - Strobe-select timing only when region bit set
// - Chip select low only in strobe phase
// - Repeat accesses until the whole request completes
// - Wait programmed turnaround before setup phase
// - Back-to-back read same region: no turnaround
// - Zero turnaround field still gives one cycle
// - Load setup, strobe, hold counts at setup
// - Address and bank valid from setup start
// - Chip select and output enable fall together
// - Chip select and output enable rise together
// - Data bus sampled at hold start
// - Address may go invalid after hold
// - Narrow device: hold goes straight to setup
// - Extra accesses keep the loaded phase counts
// - Word done, nothing pending: return to idle
// - Pending request from another region: go straight to its turnaround
// - Write enable and direction stay high
`timescale 1ns/1ps
`include "amss_rd_cfg.svh"

module async_mem_strobe_select_read #(
   parameter int NUM_CS = 4,
   parameter int ADDR_W = 22,
   parameter int REGION_W = 2
) (
   input wire logic clk, // Interface clock, 10 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic req_valid, // Read request present
   input wire logic [ADDR_W-1:0] req_addr, // Word address of the request
   input wire logic [REGION_W-1:0] req_region, // Chip-select region of the request
   output logic req_ready, // Request taken when valid and ready
   output logic [`ASRD_DATA_W-1:0] rd_data, // Assembled read word
   output logic rd_valid, // One-cycle pulse with rd_data
   input wire logic wr_pending, // Asynchronous write waiting
   output logic wr_handoff, // One-cycle pulse: write may start turnaround
   output logic busy, // Sequencer not idle
   input wire logic [NUM_CS-1:0] cfg_strobe_sel, // Strobe-select mode per region
   input wire logic [NUM_CS*`ASRD_TA_W-1:0] cfg_turnaround, // Turnaround field per region
   input wire logic [NUM_CS*`ASRD_SETUP_W-1:0] cfg_rd_setup, // Read setup field per region
   input wire logic [NUM_CS*`ASRD_STROBE_W-1:0] cfg_rd_strobe, // Read strobe field per region
   input wire logic [NUM_CS*`ASRD_HOLD_W-1:0] cfg_rd_hold, // Read hold field per region
   input wire logic [NUM_CS*`ASRD_SIZE_W-1:0] cfg_bus_size, // Device data width per region
   output logic [NUM_CS-1:0] ext_chip_select_n, // Chip selects, active low
   output logic ext_output_enable_n, // Output enable, active low
   output logic ext_write_enable_n, // Write enable, active low
   output logic ext_direction, // High for read
   output logic [ADDR_W-1:0] ext_addr_bus, // Memory address
   output logic [`ASRD_BANK_W-1:0] ext_bank_sel, // Bank address, low address bits
   input wire logic [`ASRD_DATA_W-1:0] ext_data_bus, // Data bus from memory
   output logic ext_data_oe // Data bus drive enable, never set
);

   localparam int CNT_W = `ASRD_CNT_W;
   localparam int DW = `ASRD_DATA_W;
   localparam int UA_W = ADDR_W + `ASRD_BANK_W;

   // ****************************************
   // Helper functions
   // ****************************************

   // Turnaround length for a fresh access
   function automatic logic [CNT_W-1:0] turn_len(input logic [`ASRD_TA_W-1:0] ta);
      logic [CNT_W-1:0] len;
      len = CNT_W'(ta);
      if (ta == '0) begin
         len = `ASRD_MIN_TURN;
      end
      return len;
   endfunction

   // Index of the final access of a word
   function automatic logic [1:0] last_beat(input amss_rd_pkg::bus_width_t w);
      logic [1:0] b;
      b = 2'h0;
      unique case (w)
         amss_rd_pkg::BUS_8: b = 2'h3;
         amss_rd_pkg::BUS_16: b = 2'h1;
         default: b = 2'h0;
      endcase
      return b;
   endfunction

   // Address in device units for one access
   function automatic logic [UA_W-1:0] unit_addr(input logic [ADDR_W-1:0] waddr,
                                                 input logic [1:0] beat,
                                                 input amss_rd_pkg::bus_width_t w);
      logic [UA_W-1:0] ua;
      ua = UA_W'(waddr);
      unique case (w)
         amss_rd_pkg::BUS_8: ua = {waddr, beat};
         amss_rd_pkg::BUS_16: ua = UA_W'({waddr, beat[0]});
         default: ua = UA_W'(waddr);
      endcase
      return ua;
   endfunction

   // Places one access worth of data into the word
   function automatic logic [DW-1:0] merge(input logic [DW-1:0] word,
                                           input logic [DW-1:0] din,
                                           input logic [1:0] beat,
                                           input amss_rd_pkg::bus_width_t w);
      logic [DW-1:0] res;
      res = word;
      unique case (w)
         amss_rd_pkg::BUS_8: res[beat*8 +: 8] = din[7:0];
         amss_rd_pkg::BUS_16: res[beat[0]*16 +: 16] = din[15:0];
         default: res = din;
      endcase
      return res;
   endfunction

   // ****************************************
   // State and per-request registers
   // ****************************************
   amss_rd_pkg::seq_state_t state_r, state_nxt;
   logic [ADDR_W-1:0] waddr_r, waddr_nxt;
   logic [REGION_W-1:0] region_r, region_nxt;
   amss_rd_pkg::bus_width_t size_r, size_nxt;
   logic [1:0] beat_r, beat_nxt;
   logic [CNT_W-1:0] setup_len_r, strobe_len_r, hold_len_r;
   logic load_cfg;
   logic [REGION_W-1:0] cfg_region;
   logic [DW-1:0] data_acc_r;
   logic accept, capture, word_done;
   logic tmr_load, tmr_last;
   logic [CNT_W-1:0] tmr_val, tmr_cnt, cnt_after;
   logic ready_nxt;
   logic [UA_W-1:0] ua_nxt;
   logic [`ASRD_TA_W-1:0] req_ta;
   logic [CNT_W-1:0] cfg_setup_len, cfg_strobe_len, cfg_hold_len;

   phase_timer #(.CNT_W(CNT_W)) phase_timer_inst (
      .clk(clk), .rst(rst), .load(tmr_load), .load_val(tmr_val), .cnt(tmr_cnt),
      .last(tmr_last)
   );

   // ****************************************
   // Configuration lookup
   // ****************************************
   assign cfg_region = (state_r == amss_rd_pkg::ST_HOLD || state_r == amss_rd_pkg::ST_IDLE) ?
                       req_region : region_r;
   assign req_ta = cfg_turnaround[req_region*`ASRD_TA_W +: `ASRD_TA_W];
   assign cfg_setup_len = CNT_W'(cfg_rd_setup[cfg_region*`ASRD_SETUP_W +: `ASRD_SETUP_W])
                          + `ASRD_PHASE_ADD;
   assign cfg_strobe_len = CNT_W'(cfg_rd_strobe[cfg_region*`ASRD_STROBE_W +: `ASRD_STROBE_W])
                           + `ASRD_PHASE_ADD;
   assign cfg_hold_len = CNT_W'(cfg_rd_hold[cfg_region*`ASRD_HOLD_W +: `ASRD_HOLD_W])
                         + `ASRD_PHASE_ADD;

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      tmr_load = 1'b0;
      tmr_val = '0;
      accept = 1'b0;
      capture = 1'b0;
      word_done = 1'b0;
      load_cfg = 1'b0;
      unique case (state_r)
         amss_rd_pkg::ST_IDLE: begin
            if (req_valid && req_ready) begin
               accept = 1'b1;
               state_nxt = amss_rd_pkg::ST_TURN;
               tmr_load = 1'b1;
               tmr_val = turn_len(req_ta);
            end
         end
         amss_rd_pkg::ST_TURN: begin
            if (tmr_last) begin
               state_nxt = amss_rd_pkg::ST_SETUP;
               load_cfg = 1'b1;
               tmr_load = 1'b1;
               tmr_val = cfg_setup_len;
            end
         end
         amss_rd_pkg::ST_SETUP: begin
            if (tmr_last) begin
               state_nxt = amss_rd_pkg::ST_STROBE;
               tmr_load = 1'b1;
               tmr_val = strobe_len_r;
            end
         end
         amss_rd_pkg::ST_STROBE: begin
            if (tmr_last) begin
               state_nxt = amss_rd_pkg::ST_HOLD;
               capture = 1'b1;
               tmr_load = 1'b1;
               tmr_val = hold_len_r;
            end
         end
         amss_rd_pkg::ST_HOLD: begin
            if (tmr_last) begin
               if (beat_r != last_beat(size_r)) begin
                  state_nxt = amss_rd_pkg::ST_SETUP;
                  tmr_load = 1'b1;
                  tmr_val = setup_len_r;
               end else begin
                  word_done = 1'b1;
                  if (req_valid && req_ready) begin
                     accept = 1'b1;
                     tmr_load = 1'b1;
                     if (req_region == region_r) begin
                        state_nxt = amss_rd_pkg::ST_SETUP;
                        load_cfg = 1'b1;
                        tmr_val = cfg_setup_len;
                     end else begin
                        state_nxt = amss_rd_pkg::ST_TURN;
                        tmr_val = turn_len(req_ta);
                     end
                  end else begin
                     state_nxt = amss_rd_pkg::ST_IDLE;
                  end
               end
            end
         end
      endcase
   end

   // Next request context
   always_comb begin
      waddr_nxt = waddr_r;
      region_nxt = region_r;
      size_nxt = size_r;
      beat_nxt = beat_r;
      if (accept) begin
         waddr_nxt = req_addr;
         region_nxt = req_region;
         size_nxt = amss_rd_pkg::bus_width_t'(cfg_bus_size[req_region*`ASRD_SIZE_W +:
                                                           `ASRD_SIZE_W]);
         beat_nxt = 2'h0;
      end else if (state_r == amss_rd_pkg::ST_HOLD && state_nxt == amss_rd_pkg::ST_SETUP) begin
         beat_nxt = beat_r + 2'h1;
      end
   end

   assign ua_nxt = unit_addr(waddr_nxt, beat_nxt, size_nxt);

   // Ready for the next request during idle and the final hold cycle of a word
   always_comb begin
      cnt_after = tmr_load ? tmr_val : (tmr_cnt - CNT_W'(1));
      ready_nxt = 1'b0;
      if (state_nxt == amss_rd_pkg::ST_IDLE) begin
         ready_nxt = 1'b1;
      end else if (state_nxt == amss_rd_pkg::ST_HOLD && beat_nxt == last_beat(size_nxt) &&
                   cnt_after == CNT_W'(1)) begin
         ready_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= amss_rd_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         waddr_r <= '0;
         region_r <= '0;
         size_r <= amss_rd_pkg::BUS_32;
         beat_r <= 2'h0;
      end else begin
         waddr_r <= waddr_nxt;
         region_r <= region_nxt;
         size_r <= size_nxt;
         beat_r <= beat_nxt;
      end
   end

   // Phase counts captured once per request
   always_ff @(posedge clk) begin
      if (rst) begin
         setup_len_r <= '0;
         strobe_len_r <= '0;
         hold_len_r <= '0;
      end else if (load_cfg) begin
         setup_len_r <= cfg_setup_len;
         strobe_len_r <= cfg_strobe_len;
         hold_len_r <= cfg_hold_len;
      end
   end

   // ****************************************
   // Read data assembly
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         data_acc_r <= `ASRD_DATA_RST;
      end else if (capture) begin
         data_acc_r <= merge(data_acc_r, ext_data_bus, beat_r, size_r);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data <= `ASRD_DATA_RST;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= word_done;
         if (word_done) begin
            rd_data <= data_acc_r;
         end
      end
   end

   // ****************************************
   // Handshake and status outputs
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         req_ready <= 1'b0;
         wr_handoff <= 1'b0;
         busy <= 1'b0;
      end else begin
         req_ready <= ready_nxt;
         wr_handoff <= word_done && !accept && wr_pending;
         busy <= (state_nxt != amss_rd_pkg::ST_IDLE);
      end
   end

   // ****************************************
   // Memory pins
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_chip_select_n <= {NUM_CS{`ASRD_PIN_IDLE}};
         ext_output_enable_n <= `ASRD_PIN_IDLE;
      end else begin
         ext_chip_select_n <= {NUM_CS{`ASRD_PIN_IDLE}};
         ext_output_enable_n <= `ASRD_PIN_IDLE;
         if (state_nxt == amss_rd_pkg::ST_STROBE) begin
            ext_chip_select_n[region_nxt] <= 1'b0;
            ext_output_enable_n <= 1'b0;
         end else if (!cfg_strobe_sel[region_nxt] &&
                      (state_nxt == amss_rd_pkg::ST_SETUP ||
                       state_nxt == amss_rd_pkg::ST_HOLD)) begin
            ext_chip_select_n[region_nxt] <= 1'b0;
         end
      end
   end

   // Address changes only at setup start and is left as is after hold
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_addr_bus <= '0;
         ext_bank_sel <= '0;
      end else if (state_nxt == amss_rd_pkg::ST_SETUP && state_r != amss_rd_pkg::ST_SETUP) begin
         ext_addr_bus <= ua_nxt[UA_W-1 -: ADDR_W];
         ext_bank_sel <= ua_nxt[`ASRD_BANK_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      ext_write_enable_n <= `ASRD_PIN_IDLE;
      ext_direction <= `ASRD_PIN_IDLE;
      ext_data_oe <= 1'b0;
   end

endmodule // async_mem_strobe_select_read

// ---- hdl/phase_timer.sv ----
// Down-counter that times turnaround, setup, strobe and hold phases.
`timescale 1ns/1ps
`include "amss_rd_cfg.svh"

module phase_timer #(
   parameter int CNT_W = `ASRD_CNT_W
) (
   input wire logic clk, // Interface clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic load, // Start a new phase
   input wire logic [CNT_W-1:0] load_val, // Phase length in cycles
   output logic [CNT_W-1:0] cnt, // Cycles left in this phase
   output logic last // Final cycle of the phase
);

   logic [CNT_W-1:0] cnt_r;

   // ****************************************
   // Counter
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (load) begin
         cnt_r <= load_val;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - CNT_W'(1);
      end
   end

   assign cnt = cnt_r;
   assign last = (cnt_r == CNT_W'(1));

endmodule // phase_timer

// ---- include/amss_rd_cfg.svh ----
// Constants of the strobe-select read sequencer: field widths, pin levels, timing.
`ifndef AMSS_RD_CFG_SVH
`define AMSS_RD_CFG_SVH

// ****************************************
// Per-region configuration field widths
// ****************************************
`define ASRD_TA_W 2
`define ASRD_SETUP_W 4
`define ASRD_STROBE_W 6
`define ASRD_HOLD_W 3
`define ASRD_SIZE_W 2

// ****************************************
// Datapath and counter widths
// ****************************************
`define ASRD_DATA_W 32
`define ASRD_CNT_W 8
`define ASRD_BANK_W 2

// ****************************************
// Reset and idle values, minimum turnaround and phase length offset
// ****************************************
`define ASRD_PIN_IDLE 1'b1
`define ASRD_MIN_TURN 8'h01
`define ASRD_PHASE_ADD 8'h01
`define ASRD_DATA_RST 32'h0000_0000

// ****************************************
// Timing
// ****************************************
`define ASRD_CLK_PERIOD_NS 100

`endif

// ---- include/amss_rd_pkg.sv ----
// Types of the strobe-select read sequencer.
package amss_rd_pkg;

   // Sequencer phases
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_TURN,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD
   } seq_state_t;

   // Encoding of the per-region bus size field
   typedef enum logic [1:0] {
      BUS_8 = 2'h0,
      BUS_16 = 2'h1,
      BUS_32 = 2'h2,
      BUS_RSVD = 2'h3
   } bus_width_t;

endpackage
